// File: design/scx_cfg.svh
`ifndef SCX_CFG_SVH
`define SCX_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SCX_OFF_INSTR0  8'h00
`define SCX_OFF_INSTR1  8'h04
`define SCX_OFF_SRC     8'h08
`define SCX_OFF_DST     8'h0C
`define SCX_OFF_COUNT   8'h10
`define SCX_OFF_OPERAND 8'h14
`define SCX_OFF_CTRL    8'h18
`define SCX_OFF_STATUS  8'h1C
`define SCX_OFF_PC      8'h20
`define SCX_OFF_SAVEDPC 8'h24
// ----------------------------------------
// field positions and encodings
// ----------------------------------------
`define SCX_CTRL_START  0
`define SCX_CTRL_SEG    1
`define SCX_ST_BUSY     0
`define SCX_ST_MATCH    1
`define SCX_ST_EXH      2
`define SCX_ST_INTR     3
`define SCX_ST_ILLEGAL  4
`define SCX_OPCODE      7'h5D
`define SCX_SUB_REP     4'h4
`define SCX_SUB_DUAL    4'hA
// ----------------------------------------
// timing counts in clock cycles
// ----------------------------------------
`define SCX_REP_BASE    24'h00000B
`define SCX_REP_ELEM    24'h000009
`define SCX_DUAL_TOTAL  24'h000019
`endif

// File: design/scx_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "scx_cfg.svh"
// What this block does
// - repeating scan steps source pointer by one (byte) or two (word)
// - in the same cycle as the step, count drops by one and the step repeats
// - repeating scan ends on condition true or count reaching zero
// - count covers 1..65536 bytes; software keeps word count at most 32768
// - interrupted scan saves the instruction start address for re-execution
// - repeating scan takes 11 cycles plus 9 per element
// - scan decoded from opcode, nonzero source field, sub-op 0100
// - pointers are 16 bits nonsegmented, register pair when segmented
// - dual compare subtracts source element from destination element
// - match flag set when the selected condition holds, else cleared
// - compared operands are never written back
// - dual compare steps both pointers down by one or two
// - dual compare drops count by exactly one
// - exhausted flag set when count decrements to zero, else cleared
// - repeating scan compares memory element against the register operand
// - exhausted flag at one means count now holds zero
// - dual compare sub-op 1010, nonzero pointer fields, 25 cycles
module scx_exec
(
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic [7:0]     s_axi_awaddr,
   input  wire logic           s_axi_awvalid,
   output logic                s_axi_awready,
   input  wire logic [31:0]    s_axi_wdata,
   input  wire logic [3:0]     s_axi_wstrb,
   input  wire logic           s_axi_wvalid,
   output logic                s_axi_wready,
   output logic [1:0]          s_axi_bresp,
   output logic                s_axi_bvalid,
   input  wire logic           s_axi_bready,
   input  wire logic [7:0]     s_axi_araddr,
   input  wire logic           s_axi_arvalid,
   output logic                s_axi_arready,
   output logic [31:0]         s_axi_rdata,
   output logic [1:0]          s_axi_rresp,
   output logic                s_axi_rvalid,
   input  wire logic           s_axi_rready,
   output logic                mem_req,
   output scx_pkg::scx_word_t  mem_addr,
   output logic                mem_byte,
   input  wire logic           mem_ack,
   input  wire logic [15:0]    mem_rdata,
   input  wire logic           irq_pending,
   output logic                exec_done,
   output logic                intr_taken
);
   import scx_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   scx_state_t   state_reg;
   logic [15:0]  instr0_reg;
   logic [15:0]  instr1_reg;
   scx_word_t    src_ptr_reg;
   scx_word_t    dst_ptr_reg;
   logic [15:0]  count_reg;
   logic [15:0]  operand_reg;
   logic         seg_reg;
   scx_word_t    pc_reg;
   scx_word_t    saved_pc_reg;
   logic         match_reg;
   logic         exh_reg;
   logic         intr_reg;
   logic         illegal_reg;
   logic         rep_reg;
   logic [15:0]  src_data_reg;
   logic [15:0]  dst_data_reg;
   logic [23:0]  tick_reg;
   logic [23:0]  budget_reg;
   scx_word_t    addr_reg;
   logic         done_reg;
   logic         intr_pulse_reg;
   logic [7:0]   waddr_reg;
   scx_word_t    wdata_reg;
   logic [3:0]   wstrb_reg;
   logic         aw_got_reg;
   logic         w_got_reg;
   logic         bvalid_reg;
   logic [1:0]   bresp_reg;
   logic         rvalid_reg;
   logic [1:0]   rresp_reg;
   scx_word_t    rdata_reg;

   // 16-bit registers take only the two low byte lanes
   function automatic logic [15:0] merge16(input logic [15:0] old_v, input scx_word_t new_v, input logic [3:0] be);
      logic [15:0] r;
      r = old_v;
      if (be[0])
         r[7:0] = new_v[7:0];
      if (be[1])
         r[15:8] = new_v[15:8];
      return r;
   endfunction

   function automatic scx_word_t merge(input scx_word_t old_v, input scx_word_t new_v, input logic [3:0] be);
      scx_word_t r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return r;
   endfunction

   // ----------------------------------------
   // instruction decode
   // ----------------------------------------
   wire        busy     = (state_reg != ST_IDLE);
   wire        is_word  = instr0_reg[8];
   wire [3:0]  src_fld  = instr0_reg[7:4];
   wire [3:0]  sub_op   = instr0_reg[3:0];
   wire [3:0]  dst_fld  = instr1_reg[7:4];
   wire [3:0]  condition_select = instr1_reg[3:0];
   wire        op_ok    = (instr0_reg[15:9] == `SCX_OPCODE) && (instr1_reg[15:12] == 4'h0);
   wire        scan_repeat = op_ok && (sub_op == `SCX_SUB_REP) && (src_fld != 4'h0);
   wire        dual_compare_down = op_ok && (sub_op == `SCX_SUB_DUAL) && (src_fld != 4'h0) && (dst_fld != 4'h0);
   wire [15:0] step     = is_word ? 16'h0002 : 16'h0001;
   // zero count wraps to 65536 elements
   wire [15:0] count_dec = count_reg - 16'h0001;

   // ----------------------------------------
   // compare, result kept only as flags
   // ----------------------------------------
   // register operand (scan) or destination element (dual) vs source element
   wire [15:0] opa  = rep_reg ? operand_reg : dst_data_reg;
   wire [15:0] opb  = src_data_reg;
   wire [16:0] dw   = {1'b0, opa} - {1'b0, opb};
   wire [8:0]  db   = {1'b0, opa[7:0]} - {1'b0, opb[7:0]};
   wire        f_z  = is_word ? (dw[15:0] == 16'h0000) : (db[7:0] == 8'h00);
   wire        f_c  = is_word ? dw[16] : db[8];
   wire        f_s  = is_word ? dw[15] : db[7];
   wire        f_v  = is_word ? ((opa[15] ^ opb[15]) & (opa[15] ^ dw[15]))
                              : ((opa[7] ^ opb[7]) & (opa[7] ^ db[7]));
   wire        lt   = f_s ^ f_v;
   wire [15:0] cc_tab = {~f_c, ~f_c & ~f_z, ~lt & ~f_z, ~lt, ~f_s, ~f_z, ~f_v, 1'b1,
                         f_c, f_z, f_s, f_v, f_c | f_z, lt | f_z, lt, 1'b0};
   wire        cond_true = cc_tab[condition_select];

   function automatic scx_word_t eff(input scx_word_t p, input logic seg);
      return seg ? p : {16'h0000, p[15:0]};
   endfunction

   wire [31:0] src_up   = {src_ptr_reg[31:16], src_ptr_reg[15:0] + step};
   wire [31:0] src_down = {src_ptr_reg[31:16], src_ptr_reg[15:0] - step};
   wire [31:0] dst_down = {dst_ptr_reg[31:16], dst_ptr_reg[15:0] - step};
   wire        budget_hit = (tick_reg >= budget_reg - 24'h000001);

   // ----------------------------------------
   // bus write side
   // ----------------------------------------
   wire        wr_fire  = aw_got_reg && w_got_reg && !bvalid_reg;
   wire        wr_map   = (waddr_reg[7:2] <= `SCX_OFF_SAVEDPC >> 2) && (waddr_reg[1:0] == 2'b00);
   wire        wr_ok    = wr_fire && !busy;
   wire        wr_start = wr_ok && (waddr_reg == `SCX_OFF_CTRL) && wstrb_reg[0]
                          && wdata_reg[`SCX_CTRL_START];
   wire [31:0] ctrl_new = merge({30'h0, seg_reg, 1'b0}, wdata_reg, wstrb_reg);
   assign s_axi_awready = !aw_got_reg && !bvalid_reg;
   assign s_axi_wready  = !w_got_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;

   // ----------------------------------------
   // bus read side
   // ----------------------------------------
   wire [31:0] status_v = {27'h0, illegal_reg, intr_reg, exh_reg, match_reg, busy};
   wire [7:0]  ra       = s_axi_araddr;
   wire        rd_map   = (ra[7:2] <= `SCX_OFF_SAVEDPC >> 2) && (ra[1:0] == 2'b00);
   wire [31:0] rd_mux   = (ra == `SCX_OFF_INSTR0)  ? {16'h0, instr0_reg} :
                          (ra == `SCX_OFF_INSTR1)  ? {16'h0, instr1_reg} :
                          (ra == `SCX_OFF_SRC)     ? src_ptr_reg :
                          (ra == `SCX_OFF_DST)     ? dst_ptr_reg :
                          (ra == `SCX_OFF_COUNT)   ? {16'h0, count_reg} :
                          (ra == `SCX_OFF_OPERAND) ? {16'h0, operand_reg} :
                          (ra == `SCX_OFF_CTRL)    ? {30'h0, seg_reg, 1'b0} :
                          (ra == `SCX_OFF_STATUS)  ? status_v :
                          (ra == `SCX_OFF_PC)      ? pc_reg :
                          (ra == `SCX_OFF_SAVEDPC) ? saved_pc_reg : 32'h0;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   assign mem_req    = (state_reg == ST_RD_SRC) || (state_reg == ST_RD_DST);
   assign mem_addr   = addr_reg;
   assign mem_byte   = !is_word;
   assign exec_done  = done_reg;
   assign intr_taken = intr_pulse_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= 2'b00;
         waddr_reg  <= 8'h00;
         wdata_reg  <= 32'h0;
         wstrb_reg  <= 4'h0;
         rvalid_reg <= 1'b0;
         rresp_reg  <= 2'b00;
         rdata_reg  <= 32'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_reg <= 1'b1;
            waddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_map ? 2'b00 : 2'b10;
         end
         else if (bvalid_reg && s_axi_bready)
            bvalid_reg <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_map ? 2'b00 : 2'b10;
         end
         else if (rvalid_reg && s_axi_rready)
            rvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // register file and execution sequence
   // ----------------------------------------
   // writes while busy are dropped so software never races the pointers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg      <= ST_IDLE;
         instr0_reg     <= 16'h0;
         instr1_reg     <= 16'h0;
         src_ptr_reg    <= 32'h0;
         dst_ptr_reg    <= 32'h0;
         count_reg      <= 16'h0;
         operand_reg    <= 16'h0;
         seg_reg        <= 1'b0;
         pc_reg         <= 32'h0;
         saved_pc_reg   <= 32'h0;
         match_reg      <= 1'b0;
         exh_reg        <= 1'b0;
         intr_reg       <= 1'b0;
         illegal_reg    <= 1'b0;
         rep_reg        <= 1'b0;
         src_data_reg   <= 16'h0;
         dst_data_reg   <= 16'h0;
         tick_reg       <= 24'h0;
         budget_reg     <= 24'h0;
         addr_reg       <= 32'h0;
         done_reg       <= 1'b0;
         intr_pulse_reg <= 1'b0;
      end
      else
      begin
         done_reg       <= 1'b0;
         intr_pulse_reg <= 1'b0;
         tick_reg       <= tick_reg + 24'h000001;
         if (wr_ok)
         begin
            case (waddr_reg)
               `SCX_OFF_INSTR0:  instr0_reg  <= merge16(instr0_reg, wdata_reg, wstrb_reg);
               `SCX_OFF_INSTR1:  instr1_reg  <= merge16(instr1_reg, wdata_reg, wstrb_reg);
               `SCX_OFF_SRC:     src_ptr_reg <= merge(src_ptr_reg, wdata_reg, wstrb_reg);
               `SCX_OFF_DST:     dst_ptr_reg <= merge(dst_ptr_reg, wdata_reg, wstrb_reg);
               `SCX_OFF_COUNT:   count_reg   <= merge16(count_reg, wdata_reg, wstrb_reg);
               `SCX_OFF_OPERAND: operand_reg <= merge16(operand_reg, wdata_reg, wstrb_reg);
               `SCX_OFF_CTRL:    seg_reg     <= ctrl_new[`SCX_CTRL_SEG];
               `SCX_OFF_PC:      pc_reg      <= merge(pc_reg, wdata_reg, wstrb_reg);
               default:          ;
            endcase
         end
         case (state_reg)
            ST_IDLE:
            begin
               if (wr_start)
               begin
                  tick_reg    <= 24'h0;
                  intr_reg    <= 1'b0;
                  rep_reg     <= scan_repeat;
                  illegal_reg <= !(scan_repeat || dual_compare_down);
                  addr_reg    <= eff(src_ptr_reg, seg_reg);
                  budget_reg  <= scan_repeat ? `SCX_REP_BASE + `SCX_REP_ELEM : `SCX_DUAL_TOTAL;
                  if (scan_repeat || dual_compare_down)
                     state_reg <= ST_RD_SRC;
                  else
                     done_reg  <= 1'b1;
               end
            end
            ST_RD_SRC:
            begin
               if (mem_ack)
               begin
                  src_data_reg <= mem_rdata;
                  addr_reg     <= eff(dst_ptr_reg, seg_reg);
                  state_reg    <= rep_reg ? ST_CMP : ST_RD_DST;
               end
            end
            ST_RD_DST:
            begin
               if (mem_ack)
               begin
                  dst_data_reg <= mem_rdata;
                  state_reg    <= ST_CMP;
               end
            end
            ST_CMP:
            begin
               match_reg <= cond_true;
               count_reg <= count_dec;
               exh_reg   <= (count_dec == 16'h0000);
               if (rep_reg)
                  src_ptr_reg <= src_up;
               else
               begin
                  src_ptr_reg <= src_down;
                  dst_ptr_reg <= dst_down;
               end
               state_reg <= ST_WAIT;
            end
            ST_WAIT:
            begin
               if (budget_hit)
               begin
                  if (!rep_reg || match_reg || exh_reg)
                  begin
                     state_reg <= ST_IDLE;
                     done_reg  <= 1'b1;
                  end
                  else if (irq_pending)
                  begin
                     saved_pc_reg   <= pc_reg;
                     intr_reg       <= 1'b1;
                     intr_pulse_reg <= 1'b1;
                     done_reg       <= 1'b1;
                     state_reg      <= ST_IDLE;
                  end
                  else
                  begin
                     budget_reg <= budget_reg + `SCX_REP_ELEM;
                     addr_reg   <= eff(src_ptr_reg, seg_reg);
                     state_reg  <= ST_RD_SRC;
                  end
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: design/scx_pkg.sv
package scx_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_RD_SRC, ST_RD_DST, ST_CMP, ST_WAIT} scx_state_t;
   typedef logic [31:0] scx_word_t;
endpackage

// File: tb/scx_exec_checker.sv
`timescale 1ns/1ps
`default_nettype none
module scx_exec_checker
(
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wready,
   input wire logic [1:0]         s_axi_bresp,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire logic               mem_req,
   input wire scx_pkg::scx_word_t mem_addr,
   input wire logic               mem_byte,
   input wire logic               mem_ack,
   input wire logic               exec_done,
   input wire logic               intr_taken
);
   import scx_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence mem_wait;
      mem_req && !mem_ack;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_intr_done: assert property (intr_taken |-> exec_done)
      else $error("interrupt stop without done pulse");
   chk_done_pulse: assert property (exec_done |=> !exec_done)
      else $error("done pulse longer than one cycle");
   chk_req_hold: assert property (mem_wait |=> mem_req && $stable(mem_addr))
      else $error("memory request dropped or moved");
   chk_width_hold: assert property (mem_wait |=> $stable(mem_byte))
      else $error("element width changed mid request");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
      else $error("read answer late");
endmodule
`default_nettype wire

// File: tb/scx_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scx_exec_tb;
   import scx_pkg::*;
   logic aclk = 0, aresetn = 0, irq_pending = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 0, mem_delay = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic mem_req, mem_byte, mem_ack, exec_done, intr_taken;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] mem_rdata;
   scx_word_t mem_addr;
   int errors = 0, cmp_count = 0, cyc = 0;
   scx_exec dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .mem_req, .mem_addr, .mem_byte, .mem_ack, .mem_rdata, .irq_pending,
      .exec_done, .intr_taken);
   scx_mem_model mem_i (.aclk, .aresetn, .mem_req, .mem_addr, .mem_delay, .mem_ack, .mem_rdata);
   always #10 aclk = ~aclk;
   task automatic test_done;
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // the whole run needs well under this many cycles
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         test_done;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      logic fin;
      fin = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!fin)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
         begin
            check(s_axi_bresp, er);
            s_axi_bready <= 1'b0;
            fin = 1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
      logic fin;
      fin = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!fin)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
         begin
            check(s_axi_rresp, er);
            v = s_axi_rdata;
            s_axi_rready <= 1'b0;
            fin = 1;
         end
      end
   endtask
   // i0 of zero restarts with the registers left by the previous run
   task automatic run(input logic [15:0] i0, i1, input logic [31:0] src, dst, input logic [15:0] cnt, opd,
      input logic [31:0] ctl, e_src, e_dst, e_cnt, e_st, e_cyc);
      int c;
      logic it;
      logic [31:0] v;
      if (i0 != 16'h0)
      begin
         wr(8'h00, {16'h0, i0}, 2'b00);
         wr(8'h04, {16'h0, i1}, 2'b00);
         wr(8'h08, src, 2'b00);
         wr(8'h0C, dst, 2'b00);
         wr(8'h10, {16'h0, cnt}, 2'b00);
         wr(8'h14, {16'h0, opd}, 2'b00);
         wr(8'h20, 32'h1234, 2'b00);
      end
      wr(8'h18, ctl, 2'b00);
      // the done pulse of an illegal start already stands at the response edge
      c = 0;
      while (exec_done !== 1'b1)
      begin
         @(posedge aclk);
         c++;
      end
      it = (intr_taken === 1'b1);
      check(32'(c), e_cyc);
      check({31'h0, it}, {31'h0, e_st[3]});
      rd(8'h08, v, 2'b00);
      check(v, e_src);
      rd(8'h0C, v, 2'b00);
      check(v, e_dst);
      rd(8'h10, v, 2'b00);
      check(v, e_cnt);
      rd(8'h1C, v, 2'b00);
      check(v, e_st);
   endtask
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h1C, d, 2'b00);
      check(d, 32'h0);
      wr(8'h28, 32'hFFFF, 2'b10);
      rd(8'h28, d, 2'b10);
      check(d, 32'h0);
      run(16'hBA04, 16'h0320, 32'h700, 32'h0, 16'h2, 16'h0, 32'h1, 32'h700, 32'h0, 32'h2, 32'h10, 32'h0);
      run(16'hBB1A, 16'h0306, 32'h700, 32'h0, 16'h2, 16'h0, 32'h1, 32'h700, 32'h0, 32'h2, 32'h10, 32'h0);
      // distinct source, count and destination fields
      run(16'hBA14, 16'h0326, 32'h100, 32'h0, 16'h3, 16'h12, 32'h1, 32'h102, 32'h0, 32'h1, 32'h2, 32'd29);
      run(16'hBB14, 16'h0320, 32'h30200, 32'h0, 16'h2, 16'h0, 32'h3, 32'h30204, 32'h0, 32'h0, 32'h4, 32'd29);
      run(16'hBB1A, 16'h032B, 32'h300, 32'h400, 16'h1, 16'h0, 32'h1, 32'h2FE, 32'h3FE, 32'h0, 32'h6, 32'd25);
      // slow memory stays inside the fixed budget
      mem_delay <= 4'h4;
      run(16'hBA1A, 16'h0320, 32'h310, 32'h305, 16'h5, 16'h0, 32'h1, 32'h30F, 32'h304, 32'h4, 32'h0, 32'd25);
      mem_delay <= 4'h0;
      irq_pending <= 1'b1;
      run(16'hBA14, 16'h0320, 32'h500, 32'h0, 16'h4, 16'h0, 32'h1, 32'h501, 32'h0, 32'h3, 32'h8, 32'd20);
      irq_pending <= 1'b0;
      rd(8'h24, d, 2'b00);
      check(d, 32'h1234);
      run(16'h0, 16'h0, 32'h0, 32'h0, 16'h0, 16'h0, 32'h1, 32'h504, 32'h0, 32'h0, 32'h4, 32'd38);
      test_done;
   end
endmodule
bind scx_exec scx_exec_checker chk_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .mem_req, .mem_addr, .mem_byte, .mem_ack, .exec_done, .intr_taken);
`default_nettype wire

// File: tb/scx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module scx_mem_model
(
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire logic               mem_req,
   input wire scx_pkg::scx_word_t mem_addr,
   input wire logic [3:0]         mem_delay,
   output logic                   mem_ack,
   output logic [15:0]            mem_rdata
);
   import scx_pkg::*;
   logic [3:0] wait_reg;
   // idle data toggles so a stale element never looks valid
   always_ff @(posedge aclk)
   begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!aresetn)
      begin
         wait_reg <= 4'h0;
         mem_rdata <= 16'h5A5A;
      end
      else if (mem_req && !mem_ack && wait_reg == mem_delay)
      begin
         mem_ack <= 1'b1;
         mem_rdata <= mem_addr[15:0] + 16'h1111;
         wait_reg <= 4'h0;
      end
      else if (mem_req && !mem_ack)
         wait_reg <= wait_reg + 4'h1;
   end
endmodule
`default_nettype wire
